// File: verilog/cta_pkg.sv
// Constants for the single-wire control-bus transmitter with its register file.
// Assumes a 40 MHz system clock and a slow tick derived from it at 32.768 kHz.
// How it works
// - Compare sampled line with driven level; mismatch loses.
// - Lost arbitration aborts the frame, left incomplete.
// - Always wait fixed seven free bit periods.
// - Any initiator needs five free bits minimum.
// - Polling in progress: incoming frames get NACK.
// - Frame starts three to four slow ticks after write.
// - Foreign frame at ticks 2-3 bus error, 3-4 lost.
package cta_pkg;
  // ****************************************
  // Register map (byte addresses).
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;  // Bit 0 is transmit_enable.
  localparam logic [7:0] A_SIGNAL_FREE_SETTING = 8'h04; // signal_free_setting, stored only.
  localparam logic [7:0] A_TXF = 8'h08;   // transmit_frame_reg, write starts a frame.
  localparam logic [7:0] A_RXA1 = 8'h0C;  // receive_address_one.
  localparam logic [7:0] A_RXA2 = 8'h10;  // receive_address_two.
  localparam logic [7:0] A_STS = 8'h14;   // Sticky status, read only.
  localparam logic [7:0] A_IEN = 8'h18;   // Interrupt enable.
  localparam logic [7:0] A_ICLR = 8'h1C;  // Status clear, write only.
  localparam logic [7:0] A_LINE = 8'h20;  // Live line and block state.
  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int ST_DONE = 0;  // Frame sent to the end.
  localparam int ST_BERR = 1;  // Bus error during start latency.
  localparam int ST_ARB = 2;   // Arbitration lost.
  localparam int TXF_EOM = 8;  // End-of-message bit of the frame register.
  localparam logic [3:0] ADDR_NONE = 4'hF;  // Unregistered address.
  localparam logic [3:0] SIGNAL_FREE_SETTING_RST = 4'h7;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int SLOW_HZ = 32768;
  localparam int DIV_CNT = CLK_HZ / SLOW_HZ;  // System cycles per slow tick.
  localparam int BIT_US = 2400;     // Nominal bit period.
  localparam int ZERO_US = 1500;    // Low time of a zero.
  localparam int ONE_US = 600;      // Low time of a one.
  localparam int SLOW_US = 3700;    // Low time of the start bit.
  localparam int SBIT_US = 4500;    // Whole start bit.
  localparam int SAMP_US = 1050;    // Sample point in a bit.
  localparam int BIT_TK = BIT_US * SLOW_HZ / 1000000;
  localparam int ZERO_TK = ZERO_US * SLOW_HZ / 1000000;
  localparam int ONE_TK = ONE_US * SLOW_HZ / 1000000;
  localparam int SLOW_TK = SLOW_US * SLOW_HZ / 1000000;
  localparam int SBIT_TK = SBIT_US * SLOW_HZ / 1000000;
  localparam int SAMP_TK = SAMP_US * SLOW_HZ / 1000000;
  localparam int FREE_BITS = 7;  // Fixed wait before driving.
  localparam int MIN_FREE_BITS = 5;
  localparam int LAT_BERR = 2;   // Latency tick count giving bus error.
  localparam int LAT_ARB = 3;    // Latency tick count giving lost arbitration.
  localparam int LAT_LAST = 3;   // Count at which the fourth tick ends latency.
  localparam int ACK_IDX = 9;    // Bit index of the acknowledge slot.
  // ****************************************
  // Transmit sequencer states.
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_LAT = 6'h02,
    S_WFREE = 6'h04,
    S_START = 6'h08,
    S_BIT = 6'h10,
    S_HUNG = 6'h20
  } cta_state_t;
endpackage

// File: verilog/cta_slow.sv
// Slow tick divider and line signal-free timer.
// Assumes the line input is synchronous to the system clock.
`timescale 1ns/100ps
module cta_slow #(
  parameter int DIV = cta_pkg::DIV_CNT,
  parameter int BIT_TK = cta_pkg::BIT_TK
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_line,
  output logic o_tick,
  output logic o_free_ok
);
  localparam int FREE_TK = cta_pkg::FREE_BITS * BIT_TK;
  localparam int MIN_TK = cta_pkg::MIN_FREE_BITS * BIT_TK;
  logic [11:0] div_r;   // System cycles within one slow tick.
  logic [10:0] free_r;  // Slow ticks the line has stayed high.
  // ****************************************
  // Divider: one-cycle pulse per slow period.
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= 12'h000;
      o_tick <= 1'b0;
    end else if (div_r == 12'(DIV - 1)) begin
      div_r <= 12'h000;
      o_tick <= 1'b1;
    end else begin
      div_r <= div_r + 12'h001;
      o_tick <= 1'b0;
    end
  end
  // Counts idle line time; any low level restarts it, saturates at the top.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      free_r <= 11'h000;
    end else if (!i_line) begin
      free_r <= 11'h000;
    end else if (o_tick && free_r != 11'h7FF) begin
      free_r <= free_r + 11'h001;
    end
  end
  // Line has been idle for the fixed seven-bit time. The first tick after the line goes
  // high may come at once, so one tick more is counted to keep the wait at full length.
  assign o_free_ok = free_r > 11'(FREE_TK);
  // Check helper: system cycles of high line, counted apart from the tick logic.
  logic [20:0] high_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      high_r <= 21'h000000;
    end else if (!i_line) begin
      high_r <= 21'h000000;
    end else if (high_r != 21'h1FFFFF) begin
      high_r <= high_r + 21'h000001;
    end
  end
  // ****************************************
  // Checks.
  // ****************************************
  chk_free_minimum: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_free_ok |-> high_r >= 21'(MIN_TK * DIV))
    else $error("Free flag raised before five bit periods.");
endmodule // cta_slow

// File: verilog/cta_top.sv
// Transmitter for a shared open-drain control line with an AXI4-Lite register file.
// Assumes AXI4-Lite masters per the protocol and an external wired-AND line.
`timescale 1ns/100ps
module cta_top #(
  parameter int DIV = cta_pkg::DIV_CNT,
  parameter int BIT_TK = cta_pkg::BIT_TK
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_CEC_IN,
  output logic O_CEC_OUT,
  output logic O_CEC_OE,
  output logic O_ACK_EN,
  output logic O_IRQ
);
  // ****************************************
  // Declarations.
  // ****************************************
  cta_pkg::cta_state_t state_r;  // Sequencer state.
  logic aw_got_r, w_got_r;       // Address or data of a write is held.
  logic [7:0] awaddr_r;          // Held write address.
  logic [31:0] wdata_r;          // Held write data.
  logic [3:0] wstrb_r;           // Held write strobes.
  logic wr_en;                   // Register write happens this cycle.
  logic transmit_enable_r;                  // transmit_enable.
  logic [3:0] signal_free_setting_r;           // signal_free_setting.
  logic [8:0] txf_r;             // transmit_frame_reg.
  logic [3:0] rxa1_r, rxa2_r;    // Receive addresses.
  logic [2:0] sts_r, ien_r;      // Sticky status and its enables.
  logic [2:0] evt, clr;          // Status set and clear this cycle.
  logic [7:0] tcnt_r;            // Slow ticks within a bit.
  logic [3:0] idx_r;             // Bit index, ack slot last.
  logic [2:0] lat_r;             // Slow ticks since the frame write.
  logic ack_seen_r;              // Line was low in the ack slot.
  logic tick, free_ok;           // From the slow timer.
  logic tx_go, cur_bit, polling;
  logic arb_hit, berr_hit, lat_arb, done_hit;
  // Decodes the implemented addresses, used for reads and writes alike.
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a <= cta_pkg::A_LINE) && (a[1:0] == 2'h0);
  endfunction
  cta_slow #(.DIV(DIV), .BIT_TK(BIT_TK)) u_slow (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_line(I_CEC_IN),
    .o_tick(tick),
    .o_free_ok(free_ok)
  );
  // ****************************************
  // AXI4-Lite write channel.
  // ****************************************
  assign wr_en = aw_got_r && w_got_r && !O_BVALID;
  // Takes address and data in either order, answers once both are held.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= cta_pkg::RESP_OK;
    end else begin
      O_AWREADY <= !aw_got_r && !(I_AWVALID && O_AWREADY);
      O_WREADY <= !w_got_r && !(I_WVALID && O_WREADY);
      if (I_AWVALID && O_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= I_WDATA;
        wstrb_r <= I_WSTRB;
      end
      if (wr_en) begin
        O_BVALID <= 1'b1;
        O_BRESP <= reg_known(awaddr_r) ? cta_pkg::RESP_OK : cta_pkg::RESP_ERR;
      end else if (O_BVALID && I_BREADY) begin
        // Response taken: both channels open again.
        O_BVALID <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end
  // Software registers; any nonzero strobe writes the whole field, and the frame's EOM bit 8 sits in byte 1.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      transmit_enable_r <= 1'b0;
      signal_free_setting_r <= cta_pkg::SIGNAL_FREE_SETTING_RST;
      txf_r <= 9'h000;
      rxa1_r <= cta_pkg::ADDR_NONE;
      rxa2_r <= cta_pkg::ADDR_NONE;
      ien_r <= 3'h0;
    end else if (wr_en && wstrb_r != 4'h0) begin
      case (awaddr_r)
        cta_pkg::A_CTRL: transmit_enable_r <= wdata_r[0];
        cta_pkg::A_SIGNAL_FREE_SETTING: signal_free_setting_r <= wdata_r[3:0];
        cta_pkg::A_TXF: if (tx_go) txf_r <= wdata_r[8:0];
        cta_pkg::A_RXA1: rxa1_r <= wdata_r[3:0];
        cta_pkg::A_RXA2: rxa2_r <= wdata_r[3:0];
        cta_pkg::A_IEN: ien_r <= wdata_r[2:0];
        default: ;
      endcase
    end
  end
  // ****************************************
  // AXI4-Lite read channel.
  // ****************************************
  // One read at a time; data is latched with the valid flag.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= cta_pkg::RESP_OK;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RRESP <= reg_known(I_ARADDR) ? cta_pkg::RESP_OK : cta_pkg::RESP_ERR;
      case (I_ARADDR)
        cta_pkg::A_CTRL: O_RDATA <= {31'h0, transmit_enable_r};
        cta_pkg::A_SIGNAL_FREE_SETTING: O_RDATA <= {28'h0, signal_free_setting_r};
        cta_pkg::A_TXF: O_RDATA <= {23'h0, txf_r};
        cta_pkg::A_RXA1: O_RDATA <= {28'h0, rxa1_r};
        cta_pkg::A_RXA2: O_RDATA <= {28'h0, rxa2_r};
        cta_pkg::A_STS: O_RDATA <= {29'h0, sts_r};
        cta_pkg::A_IEN: O_RDATA <= {29'h0, ien_r};
        cta_pkg::A_LINE: O_RDATA <= {28'h0, ack_seen_r, O_ACK_EN, state_r != cta_pkg::S_IDLE, I_CEC_IN};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end else begin
      O_ARREADY <= !O_RVALID;
    end
  end
  // ****************************************
  // Events of the transmit sequencer.
  // ****************************************
  // Frame write is taken only while enabled and idle.
  assign tx_go = wr_en && awaddr_r == cta_pkg::A_TXF && transmit_enable_r && state_r == cta_pkg::S_IDLE;
  assign cur_bit = (idx_r == 4'(cta_pkg::ACK_IDX)) ? 1'b1 :
                   (idx_r == 4'h8) ? txf_r[cta_pkg::TXF_EOM] : txf_r[4'h7 - idx_r[2:0]];
  // A header-only frame to its own initiator is a polling message.
  assign polling = txf_r[cta_pkg::TXF_EOM] && txf_r[7:4] == txf_r[3:0];
  // Sample point: released line read low, or driven level not seen.
  assign arb_hit = state_r == cta_pkg::S_BIT && tick && tcnt_r == 8'(cta_pkg::SAMP_TK - 1)
                   && idx_r != 4'(cta_pkg::ACK_IDX) && I_CEC_IN != cur_bit;
  assign berr_hit = state_r == cta_pkg::S_LAT && !I_CEC_IN && lat_r == 3'(cta_pkg::LAT_BERR);
  assign lat_arb = state_r == cta_pkg::S_LAT && !I_CEC_IN && lat_r == 3'(cta_pkg::LAT_ARB);
  assign done_hit = state_r == cta_pkg::S_BIT && tick && tcnt_r == 8'(BIT_TK - 1)
                    && idx_r == 4'(cta_pkg::ACK_IDX);
  assign evt = {arb_hit || lat_arb, berr_hit, done_hit};
  assign clr = (wr_en && awaddr_r == cta_pkg::A_ICLR) ? wdata_r[2:0] : 3'h0;
  // ****************************************
  // Transmit sequencer.
  // ****************************************
  // Walks latency, free wait, start bit, eight data bits, end bit, ack slot.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= cta_pkg::S_IDLE;
      O_CEC_OE <= 1'b0;
      tcnt_r <= 8'h00;
      idx_r <= 4'h0;
      lat_r <= 3'h0;
      ack_seen_r <= 1'b0;
    end else if (!transmit_enable_r) begin
      // Disabling drops any frame and frees a hung sequencer.
      state_r <= cta_pkg::S_IDLE;
      O_CEC_OE <= 1'b0;
    end else begin
      case (state_r)
        cta_pkg::S_IDLE: begin
          O_CEC_OE <= 1'b0;
          lat_r <= 3'h0;
          if (tx_go) state_r <= cta_pkg::S_LAT;
        end
        cta_pkg::S_LAT: begin
          if (berr_hit || lat_arb) begin
            state_r <= cta_pkg::S_IDLE;
          end else if (!I_CEC_IN) begin
            // Foreign frame within the first two ticks leaves it stuck.
            state_r <= cta_pkg::S_HUNG;
          end else if (tick) begin
            lat_r <= lat_r + 3'h1;
            if (lat_r == 3'(cta_pkg::LAT_LAST)) state_r <= cta_pkg::S_WFREE;
          end
        end
        cta_pkg::S_WFREE: begin
          if (free_ok) begin
            state_r <= cta_pkg::S_START;
            O_CEC_OE <= 1'b1;
            tcnt_r <= 8'h00;
          end
        end
        cta_pkg::S_START: begin
          if (tick) begin
            tcnt_r <= tcnt_r + 8'h01;
            if (tcnt_r == 8'(cta_pkg::SLOW_TK - 1)) O_CEC_OE <= 1'b0;
            if (tcnt_r == 8'(cta_pkg::SBIT_TK - 1)) begin
              state_r <= cta_pkg::S_BIT;
              tcnt_r <= 8'h00;
              idx_r <= 4'h0;
              O_CEC_OE <= 1'b1;
            end
          end
        end
        cta_pkg::S_BIT: begin
          if (arb_hit) begin
            state_r <= cta_pkg::S_IDLE;
            O_CEC_OE <= 1'b0;
          end else if (tick) begin
            tcnt_r <= tcnt_r + 8'h01;
            if (tcnt_r == (cur_bit ? 8'(cta_pkg::ONE_TK - 1) : 8'(cta_pkg::ZERO_TK - 1))) O_CEC_OE <= 1'b0;
            if (tcnt_r == 8'(cta_pkg::SAMP_TK - 1) && idx_r == 4'(cta_pkg::ACK_IDX)) ack_seen_r <= !I_CEC_IN;
            if (done_hit) begin
              state_r <= cta_pkg::S_IDLE;
            end else if (tcnt_r == 8'(BIT_TK - 1)) begin
              idx_r <= idx_r + 4'h1;
              tcnt_r <= 8'h00;
              O_CEC_OE <= 1'b1;
            end
          end
        end
        cta_pkg::S_HUNG: O_CEC_OE <= 1'b0;
        default: state_r <= cta_pkg::S_IDLE;
      endcase
    end
  end
  // ****************************************
  // Status, interrupt and line outputs.
  // ****************************************
  // Sticky flags: an event in the clearing cycle survives.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sts_r <= 3'h0;
    end else begin
      sts_r <= (sts_r & ~clr) | evt;
    end
  end
  // Interrupt level follows enabled status one cycle later.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(sts_r & ien_r);
    end
  end
  // Receive side acknowledges only when not polling and an address is set.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ACK_EN <= 1'b0;
      O_CEC_OUT <= 1'b0;
    end else begin
      O_ACK_EN <= !(polling && state_r != cta_pkg::S_IDLE)
                  && (rxa1_r != cta_pkg::ADDR_NONE || rxa2_r != cta_pkg::ADDR_NONE);
      O_CEC_OUT <= 1'b0;
    end
  end
  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  chk_arb_abort: assert property (arb_hit |=> state_r == cta_pkg::S_IDLE && !O_CEC_OE)
    else $error("Frame not aborted after lost arbitration.");
  chk_arb_flag: assert property ((arb_hit || lat_arb) |=> sts_r[cta_pkg::ST_ARB])
    else $error("Lost arbitration not flagged.");
  chk_start_free: assert property (state_r == cta_pkg::S_WFREE ##1 state_r == cta_pkg::S_START
    |-> $past(free_ok))
    else $error("Start driven before the line was free.");
  chk_start_latency: assert property (state_r == cta_pkg::S_LAT ##1 state_r == cta_pkg::S_WFREE
    |-> lat_r == 3'h4)
    else $error("Start latency is not four slow ticks.");
  chk_bus_error: assert property (berr_hit |=> sts_r[cta_pkg::ST_BERR] && state_r == cta_pkg::S_IDLE)
    else $error("Bus error not flagged in latency.");
  chk_poll_nack: assert property (polling && state_r == cta_pkg::S_BIT |=> !O_ACK_EN)
    else $error("Acknowledge allowed while polling.");
  chk_irq_level: assert property (##1 O_IRQ == $past(|(sts_r & ien_r)))
    else $error("Interrupt level does not follow enabled status.");
  chk_set_wins: assert property (evt[cta_pkg::ST_BERR] && clr[cta_pkg::ST_BERR]
    |=> sts_r[cta_pkg::ST_BERR])
    else $error("Clear beat a simultaneous bus error.");
  chk_bvalid_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("Write response dropped before taken.");
  cov_frame_done: cover property (done_hit);
  cov_arb_lost: cover property (arb_hit);
  cov_bus_error: cover property (berr_hit);
  cov_hung: cover property (state_r == cta_pkg::S_HUNG ##1 state_r == cta_pkg::S_IDLE);
endmodule // cta_top

// File: sim/cta_node.sv
// Model of another node sharing the open-drain control line.
// Assumes the bench raises its requests just after a rising clock edge.
`timescale 1ns/100ps
module cta_node #(
  parameter int FREE_CYC = 1600
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_dut_oe,
  input wire logic i_dut_out,
  input wire logic i_pull,
  input wire logic i_late,
  output logic o_line
);
  int free_cnt;  // Cycles the line has stayed high.
  logic pull_r;  // High while this node pulls the line low.
  // A frame starts only on a quiet line, unless the bench orders a collision.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      free_cnt <= 0;
      pull_r <= 1'b0;
    end else begin
      free_cnt <= o_line ? free_cnt + 1 : 0;
      pull_r <= i_pull & (pull_r | i_late | (free_cnt >= FREE_CYC));
    end
  end
  // The pull-up keeps the wire high unless a party pulls it low.
  assign o_line = (i_dut_oe ? i_dut_out : 1'b1) & ~pull_r;
endmodule // cta_node

// File: sim/cta_top_tb.sv
// Self-checking bench for the line transmitter and its register file.
// Assumes a shortened slow tick and bit period set through parameters.
`timescale 1ns/100ps
module cta_top_tb;
  localparam int DV = 8;  // System cycles per slow tick.
  localparam int BT = 60;  // Slow ticks per bit; must exceed the 49-tick low time of a zero.
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pull = 1'b0;  // Node starts a frame.
  logic late = 1'b0;  // Node collides on a busy line.
  logic line;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, oe, cec_o, ack_en, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int cyc = 0;
  int bad_count = 0;
  int total_checks = 0;
  int ph = 0;  // Slow tick phase seen when the line drive begins.
  cta_top #(.DIV(DV), .BIT_TK(BT)) cta_top_i (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(aw_rdy), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(w_rdy), .O_BRESP(bresp), .O_BVALID(b_vld), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(ar_rdy), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(r_vld), .I_RREADY(rready), .I_CEC_IN(line), .O_CEC_OUT(cec_o), .O_CEC_OE(oe),
    .O_ACK_EN(ack_en), .O_IRQ(irq));
  cta_node #(.FREE_CYC(5 * BT * DV)) cta_node_i (.i_clk(clk), .i_arst_n(arst_n), .i_dut_oe(oe),
    .i_dut_out(cec_o), .i_pull(pull), .i_late(late), .o_line(line));
  // The clock toggles every half period of 12.5 ns.
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Cycle counter; a hang is cut short here.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end
  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One write; the bus response is compared with the expected code.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = cta_pkg::RESP_OK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy) awvalid <= 1'b0;
      if (w_rdy) wvalid <= 1'b0;
    end while (!b_vld);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy) arvalid <= 1'b0;
    end while (!r_vld);
    v = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = cta_pkg::RESP_OK);
    logic [31:0] v;
    rd(a, v, er);
    chk(v, ex);
  endtask
  // Waits for the next drive pulse; gives its start cycle and length.
  task automatic pulse(output int r, output int w);
    while (!oe) @(posedge clk);
    r = cyc;
    w = 0;
    while (oe) begin
      @(posedge clk);
      w++;
    end
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_regs();
    logic [7:0] ad [10] = '{cta_pkg::A_CTRL, cta_pkg::A_SIGNAL_FREE_SETTING, cta_pkg::A_TXF, cta_pkg::A_RXA1,
      cta_pkg::A_RXA2, cta_pkg::A_STS, cta_pkg::A_IEN, cta_pkg::A_ICLR, cta_pkg::A_LINE, 8'h24};
    logic [3:0] ex [10] = '{4'h0, 4'h7, 4'h0, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0};
    for (int i = 0; i < 10; i++) rc(ad[i], {28'h0, ex[i]}, i == 9 ? cta_pkg::RESP_ERR : cta_pkg::RESP_OK);
    wr(8'h24, 32'h1, cta_pkg::RESP_ERR);
    wr(cta_pkg::A_STS, 32'h7);
    rc(cta_pkg::A_STS, 32'h0);
  endtask
  task automatic t_frame();
    int t0, r, w;
    wr(cta_pkg::A_CTRL, 32'h1);
    wr(cta_pkg::A_IEN, 32'h1);
    cw(8 * BT * DV);
    t0 = cyc;
    wr(cta_pkg::A_TXF, 32'h14F);
    pulse(r, w);
    ph = r % DV;
    chk(32'(r - t0 >= 2 * DV + 2 && r - t0 <= 4 * DV + 6), 32'h1);
    // Drive begins two cycles after the tick that ends the wait, so the start low is one cycle short.
    chk(32'(w), 32'(cta_pkg::SLOW_TK * DV - 1));
    pulse(r, w);
    chk(32'(w), 32'(cta_pkg::ZERO_TK * DV));
    while (!irq) @(posedge clk);
    rc(cta_pkg::A_STS, 32'h1);
    wr(cta_pkg::A_IEN, 32'h0);
    cw(2);
    chk({31'h0, irq}, 32'h0);
    wr(cta_pkg::A_IEN, 32'h1);
    cw(2);
    chk({31'h0, irq}, 32'h1);
    wr(cta_pkg::A_ICLR, 32'h1);
    cw(2);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, cec_o}, 32'h0);
    rc(cta_pkg::A_STS, 32'h0);
  endtask
  task automatic t_poll();
    int t0, r, w;
    wr(cta_pkg::A_SIGNAL_FREE_SETTING, 32'h0);
    wr(cta_pkg::A_RXA1, 32'h4);
    chk({31'h0, ack_en}, 32'h1);
    cw(5 * BT * DV + 16);
    pull <= 1'b1;
    cw(100);
    pull <= 1'b0;
    t0 = cyc;
    wr(cta_pkg::A_TXF, 32'h144);
    chk({31'h0, ack_en}, 32'h0);
    pulse(r, w);
    chk(32'(r - t0 >= cta_pkg::FREE_BITS * BT * DV), 32'h1);
    chk(32'(r - t0 <= (cta_pkg::FREE_BITS * BT + 2) * DV + 6), 32'h1);
    chk({31'h0, ack_en}, 32'h0);
    while (!irq) @(posedge clk);
    chk({31'h0, ack_en}, 32'h1);
    wr(cta_pkg::A_ICLR, 32'h1);
    wr(cta_pkg::A_RXA1, 32'hF);
    chk({31'h0, ack_en}, 32'h0);
    wr(cta_pkg::A_RXA1, 32'h4);
    chk({31'h0, ack_en}, 32'h1);
  endtask
  task automatic t_arb();
    int r, w;
    wr(cta_pkg::A_TXF, 32'h0FF);
    pulse(r, w);
    pulse(r, w);
    late <= 1'b1;
    pull <= 1'b1;
    w = 0;
    repeat (4 * BT * DV) begin
      @(posedge clk);
      w += oe;
    end
    late <= 1'b0;
    pull <= 1'b0;
    chk(32'(w), 32'h0);
    rc(cta_pkg::A_STS, 32'h4);
    wr(cta_pkg::A_ICLR, 32'h7);
  endtask
  // Foreign frames at one, two and three ticks into the start latency.
  task automatic t_lat();
    int dl [3] = '{8, 16, 24};
    logic [3:0] ex [3] = '{4'h0, 4'h2, 4'h4};
    int t0;
    logic [31:0] v;
    for (int i = 0; i < 3; i++) begin
      cw(5 * BT * DV + 16);
      while (cyc % DV != ph) @(posedge clk);
      t0 = cyc;
      wr(cta_pkg::A_TXF, 32'h04F);
      while (cyc < t0 + dl[i]) @(posedge clk);
      pull <= 1'b1;
      cw(100);
      pull <= 1'b0;
      cw(8 * DV);
      rc(cta_pkg::A_STS, {28'h0, ex[i]});
      rd(cta_pkg::A_LINE, v, cta_pkg::RESP_OK);
      chk(v & 32'h2, i == 0 ? 32'h2 : 32'h0);
      wr(cta_pkg::A_CTRL, 32'h0);
      wr(cta_pkg::A_CTRL, 32'h1);
      rd(cta_pkg::A_LINE, v, cta_pkg::RESP_OK);
      chk(v & 32'h2, 32'h0);
      wr(cta_pkg::A_ICLR, 32'h7);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_frame();
    t_poll();
    t_arb();
    t_lat();
    results();
  end
endmodule // cta_top_tb
